/* icu_pkg.sv */
// constants, field layout and mode encodings of the input capture unit
//
// Overview of operation
// - latch selected timebase on a qualifying event
// - three-bit mode field in control low bits
// - falling mode: capture every high-to-low edge
// - rising mode: capture every low-to-high edge
// - divide-by-four: capture every fourth rising edge
// - divide-by-sixteen: capture every sixteenth rising edge
// - both-edges mode: capture rising and falling edges
// - start on chosen edge, then every edge
// - four-entry first-in first-out capture queue
// - interrupt after selected number of captures
// - rising edge interrupts during sleep or idle
// - enable, flag, priority, subpriority bits exist
// - unimplemented bits always read as zero
// - clear alias clears written-one control bits
// - set alias sets written-one control bits
// - invert alias toggles written-one control bits
// - captured values read at buffer offset 0x10
package icu_pkg;

  // register byte offsets
  localparam logic [7:0] ICU_OFS_CTRL = 8'h00;
  localparam logic [7:0] ICU_OFS_CLR = 8'h04;
  localparam logic [7:0] ICU_OFS_SET = 8'h08;
  localparam logic [7:0] ICU_OFS_INV = 8'h0c;
  localparam logic [7:0] ICU_OFS_BUF = 8'h10;
  localparam logic [7:0] ICU_OFS_IRQ = 8'h20;

  // capture_control field positions
  localparam int ICU_BIT_ON = 15;
  localparam int ICU_BIT_FREEZE = 14;
  localparam int ICU_BIT_IDLE_HALT = 13;
  localparam int ICU_BIT_FIRST_EDGE = 9;
  localparam int ICU_BIT_WIDE = 8;
  localparam int ICU_BIT_TMR = 7;
  localparam int ICU_BIT_EVT_HI = 6;
  localparam int ICU_BIT_EVT_LO = 5;
  localparam int ICU_BIT_OVF = 4;
  localparam int ICU_BIT_BNE = 3;
  localparam int ICU_BIT_MODE_HI = 2;

  // software-writable control bits and reset value
  localparam logic [31:0] ICU_CTRL_WR_MASK = 32'h0000_e3e7;
  localparam logic [31:0] ICU_CTRL_RESET = 32'h0000_0000;

  // irq register layout: enable, flag, priority, subpriority
  localparam int ICU_IRQ_EN = 0;
  localparam int ICU_IRQ_FLAG = 1;
  localparam int ICU_IRQ_PRI_LO = 2;
  localparam int ICU_IRQ_SUB_LO = 5;
  localparam logic [31:0] ICU_IRQ_WR_MASK = 32'h0000_007f;
  localparam logic [31:0] ICU_IRQ_RESET = 32'h0000_0000;

  // queue depth and prescaler terminal counts
  localparam logic [2:0] ICU_FIFO_DEPTH = 3'h4;
  localparam logic [3:0] ICU_DIV4_LAST = 4'h3;
  localparam logic [3:0] ICU_DIV16_LAST = 4'hf;

  typedef enum logic [2:0] {
    ICU_MODE_OFF = 3'b000,
    ICU_MODE_BOTH = 3'b001,
    ICU_MODE_FALL = 3'b010,
    ICU_MODE_RISE = 3'b011,
    ICU_MODE_DIV4 = 3'b100,
    ICU_MODE_DIV16 = 3'b101,
    ICU_MODE_FIRST = 3'b110,
    ICU_MODE_WAKE = 3'b111
  } icu_mode_type;

endpackage

/* icu_top.sv */
// input capture unit: pin edge detect, capture queue and wishbone registers
`timescale 1ns/1ps
module icu_top
  import icu_pkg::*;
#(
  parameter int TB_WIDTH = 32
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // capture pin and timebases
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic [TB_WIDTH-1:0] TIMEBASE_A,
  input wire logic [TB_WIDTH-1:0] TIMEBASE_B,
  // device power and debug state
  input wire logic DEVICE_SLEEP,
  input wire logic DEVICE_IDLE,
  input wire logic DEBUG_HALT,
  // interrupt request towards the interrupt controller
  output logic CAPTURE_IRQ,
  output logic [2:0] CAPTURE_IRQ_PRIORITY,
  output logic [1:0] CAPTURE_IRQ_SUBPRIORITY
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] ctrl;
  logic [31:0] irq_reg;
  logic ack;
  logic [31:0] rdata;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic [3:0] presc;
  logic started;
  logic [1:0] evt_cnt;
  logic [31:0] fifo_mem [0:3];
  logic [1:0] wr_ptr;
  logic [1:0] rd_ptr;
  logic [2:0] fifo_cnt;
  logic overrun;
  logic rd_full;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire bus_req = WB_CYC_I & WB_STB_I;
  // the request is taken at the edge where ack is already high
  wire bus_take = bus_req & ack;
  wire wr_take = bus_take & WB_WE_I;
  wire rd_take = bus_take & ~WB_WE_I;
  wire [31:0] lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}},
    {8{WB_SEL_I[0]}}};
  wire hit_ctrl = WB_ADR_I == ICU_OFS_CTRL;
  wire hit_clr = WB_ADR_I == ICU_OFS_CLR;
  wire hit_set = WB_ADR_I == ICU_OFS_SET;
  wire hit_inv = WB_ADR_I == ICU_OFS_INV;
  wire hit_buf = WB_ADR_I == ICU_OFS_BUF;
  wire hit_irq = WB_ADR_I == ICU_OFS_IRQ;
  wire [31:0] wbits = WB_DAT_I & lane_mask & ICU_CTRL_WR_MASK;
  wire [31:0] ctrl_sw = ctrl & ICU_CTRL_WR_MASK;

  // control next value; status bits are not held here
  wire [31:0] next_ctrl =
    (wr_take && hit_ctrl) ? ((ctrl_sw & ~(lane_mask & ICU_CTRL_WR_MASK)) | wbits) :
    (wr_take && hit_clr) ? (ctrl_sw & ~wbits) :
    (wr_take && hit_set) ? (ctrl_sw | wbits) :
    (wr_take && hit_inv) ? (ctrl_sw ^ wbits) :
    ctrl_sw;

  ////////////////////////////////////////////////////////////////////////////
  // control fields

  wire on = ctrl[ICU_BIT_ON];
  wire debug_freeze = ctrl[ICU_BIT_FREEZE];
  wire halt_in_idle = ctrl[ICU_BIT_IDLE_HALT];
  wire first_rise = ctrl[ICU_BIT_FIRST_EDGE];
  wire wide = ctrl[ICU_BIT_WIDE];
  wire tmr_sel = ctrl[ICU_BIT_TMR];
  wire [1:0] evt_sel = ctrl[ICU_BIT_EVT_HI:ICU_BIT_EVT_LO];
  icu_mode_type mode;
  assign mode = icu_mode_type'(ctrl[ICU_BIT_MODE_HI:0]);

  // capturing pauses in sleep, in halted idle and in frozen debug
  wire active = on & ~DEVICE_SLEEP & ~(halt_in_idle & DEVICE_IDLE) &
    ~(debug_freeze & DEBUG_HALT);
  wire low_power = DEVICE_SLEEP | DEVICE_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detect

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= CAPTURE_INPUT_PIN;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire rise = pin_sync & ~pin_prev;
  wire fall = ~pin_sync & pin_prev;
  wire any_edge = rise | fall;
  wire first_hit = first_rise ? rise : fall;

  ////////////////////////////////////////////////////////////////////////////
  // capture event selection

  wire presc_run = (mode == ICU_MODE_DIV4) | (mode == ICU_MODE_DIV16);
  wire [3:0] presc_last = (mode == ICU_MODE_DIV4) ? ICU_DIV4_LAST : ICU_DIV16_LAST;
  wire presc_hit = rise & (presc == presc_last);
  wire cap_evt = active & (
    ((mode == ICU_MODE_FALL) & fall) |
    ((mode == ICU_MODE_RISE) & rise) |
    ((mode == ICU_MODE_DIV4) & presc_hit) |
    ((mode == ICU_MODE_DIV16) & presc_hit) |
    ((mode == ICU_MODE_BOTH) & any_edge) |
    ((mode == ICU_MODE_FIRST) & (started ? any_edge : first_hit)));
  // wake mode raises the flag directly from a rising edge
  wire wake_evt = on & (mode == ICU_MODE_WAKE) & low_power & rise;

  // prescaler counts rising edges and restarts on its terminal count
  wire [3:0] next_presc = (!active || !presc_run) ? 4'h0 :
    presc_hit ? 4'h0 :
    rise ? 4'(presc + 4'h1) : presc;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      presc <= 4'h0;
      started <= 1'b0;
    end else begin
      presc <= next_presc;
      started <= on & (mode == ICU_MODE_FIRST) & (started | (active & first_hit));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured value

  wire [TB_WIDTH-1:0] tb_pick = tmr_sel ? TIMEBASE_A : TIMEBASE_B;
  wire [31:0] tb_full = 32'(tb_pick);
  wire [31:0] sample = wide ? tb_full : {16'h0000, tb_full[15:0]};

  ////////////////////////////////////////////////////////////////////////////
  // capture queue

  wire fifo_full = fifo_cnt == ICU_FIFO_DEPTH;
  wire push = cap_evt & ~fifo_full;
  // pop only what the read answered with; a capture landing mid-read stays queued
  wire pop = rd_take & hit_buf & rd_full;
  wire [2:0] next_fifo_cnt = !on ? 3'h0 : 3'(fifo_cnt + {2'b00, push} - {2'b00, pop});

  // storage has no reset; only the pointers decide what is valid
  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      fifo_mem[wr_ptr] <= sample;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fifo_cnt <= 3'h0;
      overrun <= 1'b0;
    end else begin
      wr_ptr <= !on ? 2'h0 : 2'(wr_ptr + {1'b0, push});
      rd_ptr <= !on ? 2'h0 : 2'(rd_ptr + {1'b0, pop});
      fifo_cnt <= next_fifo_cnt;
      // overrun is sticky until the unit is switched off
      overrun <= on & (overrun | (cap_evt & fifo_full));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt event counter and irq register

  wire evt_done = cap_evt & (evt_cnt == evt_sel);
  wire [1:0] next_evt_cnt = !on ? 2'h0 : evt_done ? 2'h0 :
    cap_evt ? 2'(evt_cnt + 2'h1) : evt_cnt;
  wire irq_set = evt_done | wake_evt;
  wire irq_wr = wr_take & hit_irq;
  wire [31:0] irq_wbits = (WB_DAT_I & lane_mask & ICU_IRQ_WR_MASK) |
    (irq_reg & ~(lane_mask & ICU_IRQ_WR_MASK));
  // a hardware event in the clearing cycle still sets the flag
  wire [31:0] next_irq = irq_wr ? (irq_wbits | (32'(irq_set) << ICU_IRQ_FLAG)) :
    (irq_reg | (32'(irq_set) << ICU_IRQ_FLAG));

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      evt_cnt <= 2'h0;
      irq_reg <= ICU_IRQ_RESET;
    end else begin
      evt_cnt <= next_evt_cnt;
      irq_reg <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ctrl <= ICU_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and ack

  // status bits are merged live; unused positions stay zero
  wire [31:0] ctrl_view = ctrl_sw | ({31'h0, overrun} << ICU_BIT_OVF) |
    ({31'h0, fifo_cnt != 3'h0} << ICU_BIT_BNE);
  // alias reads return zero, software is told not to use them
  wire [31:0] next_rdata =
    hit_ctrl ? ctrl_view :
    hit_buf ? ((fifo_cnt != 3'h0) ? fifo_mem[rd_ptr] : 32'h0000_0000) :
    hit_irq ? (irq_reg & ICU_IRQ_WR_MASK) :
    32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      rd_full <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
      rd_full <= bus_req & ~ack & ~WB_WE_I & hit_buf & (fifo_cnt != 3'h0);
      rdata <= (bus_req & ~ack & ~WB_WE_I) ? next_rdata : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rdata;
  assign CAPTURE_IRQ = irq_reg[ICU_IRQ_EN] & irq_reg[ICU_IRQ_FLAG];
  assign CAPTURE_IRQ_PRIORITY = irq_reg[ICU_IRQ_PRI_LO +: 3];
  assign CAPTURE_IRQ_SUBPRIORITY = irq_reg[ICU_IRQ_SUB_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  reserved_zero_a: assert property (
    (ack && hit_ctrl && !WB_WE_I) |-> (WB_DAT_O[31:16] == 16'h0000))
    else $error("reserved control bits read nonzero");

  fall_capture_a: assert property (
    (active && mode == ICU_MODE_FALL && fall) |-> cap_evt)
    else $error("falling edge not captured");

  rise_capture_a: assert property (
    (active && mode == ICU_MODE_RISE && fall) |-> !cap_evt)
    else $error("falling edge captured in rising mode");

  div_four_a: assert property (
    (cap_evt && mode == ICU_MODE_DIV4) |-> (presc == 4'h3 && rise))
    else $error("divide by four captured off count");

  fifo_depth_a: assert property (
    fifo_cnt <= ICU_FIFO_DEPTH)
    else $error("queue count above depth");

  capture_store_a: assert property (
    push |=> (fifo_mem[$past(wr_ptr)] == $past(sample)))
    else $error("captured value not stored");

  buffer_pop_a: assert property (
    (pop && !push && on) |=> (fifo_cnt == $past(fifo_cnt) - 3'h1))
    else $error("buffer read did not pop");

  overrun_keep_a: assert property (
    (cap_evt && fifo_full && on && !pop) |=> (overrun && fifo_cnt == 3'h4 &&
      wr_ptr == $past(wr_ptr)))
    else $error("full queue capture mishandled");

  irq_count_a: assert property (
    (cap_evt && evt_cnt == evt_sel) |=> irq_reg[ICU_IRQ_FLAG])
    else $error("interrupt flag missed after event count");

  clear_alias_a: assert property (
    (wr_take && hit_clr) |=> ((ctrl & $past(wbits)) == 32'h0000_0000))
    else $error("clear alias left bits set");

  set_alias_a: assert property (
    (wr_take && hit_set) |=> ((ctrl & $past(wbits)) == $past(wbits)))
    else $error("set alias left bits clear");

  ack_single_a: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

  rise_taken_a: assert property (
    (active && mode == ICU_MODE_RISE && rise) |-> cap_evt)
    else $error("rising edge not captured");

  fall_only_a: assert property (
    (active && mode == ICU_MODE_FALL && rise) |-> !cap_evt)
    else $error("rising edge captured in falling mode");

  div_sixteen_a: assert property (
    (cap_evt && mode == ICU_MODE_DIV16) |-> (presc == 4'hf && rise))
    else $error("divide by sixteen captured off count");

  both_edges_a: assert property (
    (active && mode == ICU_MODE_BOTH && any_edge) |-> cap_evt)
    else $error("edge missed in both-edges mode");

  first_wait_a: assert property (
    (active && mode == ICU_MODE_FIRST && !started && !first_hit) |-> !cap_evt)
    else $error("capture before the first edge");

  first_every_a: assert property (
    (active && mode == ICU_MODE_FIRST && started && any_edge) |-> cap_evt)
    else $error("edge missed after the first edge");

  wake_flag_a: assert property (
    (on && mode == ICU_MODE_WAKE && low_power && rise) |=> irq_reg[ICU_IRQ_FLAG])
    else $error("wake edge did not set the flag");

  invert_alias_a: assert property (
    (wr_take && hit_inv) |=> ((ctrl ^ $past(ctrl)) == $past(wbits)))
    else $error("invert alias toggled wrong bits");

  pick_first_a: assert property (
    (push && wide && tmr_sel) |-> (sample == 32'(TIMEBASE_A)))
    else $error("first timebase not sampled");

  pick_second_a: assert property (
    (push && wide && !tmr_sel) |-> (sample == 32'(TIMEBASE_B)))
    else $error("second timebase not sampled");

  narrow_value_a: assert property (
    (push && !wide) |-> (sample[31:16] == 16'h0000))
    else $error("narrow capture has upper bits set");

  queue_filled_a: assert property (
    push |=> (fifo_cnt != 3'h0))
    else $error("queue empty after a capture");

  mode_idle_a: assert property (
    (mode == ICU_MODE_OFF || mode == ICU_MODE_WAKE) |-> !cap_evt)
    else $error("capture in a non-capturing mode");

  pause_block_a: assert property (
    (DEVICE_SLEEP || (DEBUG_HALT && debug_freeze) || (DEVICE_IDLE && halt_in_idle))
      |-> !cap_evt)
    else $error("capture while paused");

  irq_zero_a: assert property (
    (ack && hit_irq && !WB_WE_I) |-> (WB_DAT_O[31:7] == 25'h0))
    else $error("reserved irq bits read nonzero");

  irq_enable_a: assert property (
    (irq_wr && WB_SEL_I[0] && WB_DAT_I[ICU_IRQ_EN]) |=> irq_reg[ICU_IRQ_EN])
    else $error("interrupt enable not written");

  buffer_data_a: assert property (
    (rd_take && hit_buf && rd_full) |-> (WB_DAT_O == fifo_mem[rd_ptr]))
    else $error("buffer read returned wrong entry");

  empty_read_a: assert property (
    (rd_take && hit_buf && !rd_full) |-> (WB_DAT_O == 32'h0000_0000))
    else $error("empty buffer read nonzero");

endmodule

/* icu_pin_src.sv */
// capture pin source: drives the external input with timed levels
`timescale 1ns/1ps
module icu_pin_src (
  // clock of the driving side
  input wire logic clk,
  // capture pin towards the unit
  output logic pin
);
  // push-pull driver, so the pin always shows a driven level
  initial pin = 1'b0;
  // each level stands 5 cycles, wider than the two-flop synchroniser needs
  task automatic level(input logic v);
    pin <= v;
    repeat (5) @(posedge clk);
  endtask
  // one high pulse, then back to low
  task automatic pulse();
    level(1'b1);
    level(1'b0);
  endtask
endmodule

/* tb_top.sv */
// self-checking bench of the input capture unit
`timescale 1ns/1ps
module tb_top;
  import icu_pkg::*;
  logic clk, nrst, cyc, stb, we, ack, pin, sleep, idle, halt, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, tba, tbb;
  logic [2:0] pri;
  logic [1:0] sub;
  int err_count = 0;
  int tests_run = 0;
  //////////////////////////////////////////////////////////////////
  // select lanes stay all on: byte masking is left untested
  icu_top dut (.CLK_SYS(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CAPTURE_INPUT_PIN(pin),
    .TIMEBASE_A(tba), .TIMEBASE_B(tbb), .DEVICE_SLEEP(sleep),
    .DEVICE_IDLE(idle), .DEBUG_HALT(halt), .CAPTURE_IRQ(irq),
    .CAPTURE_IRQ_PRIORITY(pri), .CAPTURE_IRQ_SUBPRIORITY(sub));
  icu_pin_src src (.clk(clk), .pin(pin));
  //////////////////////////////////////////////////////////////////
  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // turning the unit off first flushes the queue and counters
  task automatic burst(input logic [31:0] c, input int n);
    wr(ICU_OFS_CTRL, 32'h0);
    wr(ICU_OFS_CTRL, c);
    for (int i = 1; i <= n; i++) begin
      tba <= i;
      tbb <= 32'habcd_0000 + i;
      src.pulse();
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc(ICU_OFS_CTRL, 32'h0);
    rdc(8'h14, 32'h0);
    wr(ICU_OFS_CTRL, 32'hffff_ffff);
    rdc(ICU_OFS_CTRL, 32'h0000_e3e7);
    wr(ICU_OFS_CLR, 32'h0000_8200);
    rdc(ICU_OFS_CTRL, 32'h0000_61e7);
    wr(ICU_OFS_SET, 32'h0000_0200);
    rdc(ICU_OFS_CTRL, 32'h0000_63e7);
    wr(ICU_OFS_INV, 32'h0000_8007);
    rdc(ICU_OFS_CTRL, 32'h0000_e3e0);
  endtask
  task automatic t_modes();
    burst(32'h8183, 2);
    rdc(ICU_OFS_CTRL, 32'h818b);
    rdc(ICU_OFS_BUF, 32'h1);
    rdc(ICU_OFS_BUF, 32'h2);
    rdc(ICU_OFS_BUF, 32'h0);
    burst(32'h8002, 2);
    rdc(ICU_OFS_BUF, 32'h1);
    rdc(ICU_OFS_BUF, 32'h2);
    burst(32'h8181, 2);
    rdc(ICU_OFS_BUF, 32'h1);
    rdc(ICU_OFS_BUF, 32'h1);
    rdc(ICU_OFS_BUF, 32'h2);
    burst(32'h8184, 8);
    rdc(ICU_OFS_BUF, 32'h4);
    rdc(ICU_OFS_BUF, 32'h8);
    burst(32'h8185, 16);
    rdc(ICU_OFS_BUF, 32'h10);
    rdc(ICU_OFS_BUF, 32'h0);
  endtask
  // fifth capture meets a full queue
  task automatic t_ovf();
    burst(32'h8183, 5);
    rdc(ICU_OFS_CTRL, 32'h819b);
    for (int i = 1; i <= 4; i++) rdc(ICU_OFS_BUF, i);
    rdc(ICU_OFS_CTRL, 32'h8193);
  endtask
  // first edge rising: a leading fall is ignored, then every edge counts
  task automatic t_first();
    src.level(1'b1);
    burst(32'h8386, 0);
    tba <= 32'h7;
    src.level(1'b0);
    tba <= 32'h8;
    src.level(1'b1);
    tba <= 32'h9;
    src.level(1'b0);
    rdc(ICU_OFS_BUF, 32'h8);
    rdc(ICU_OFS_BUF, 32'h9);
  endtask
  task automatic t_irq();
    wr(ICU_OFS_IRQ, 32'h55);
    @(posedge clk);
    chk({29'h0, pri}, 32'h5);
    chk({30'h0, sub}, 32'h2);
    burst(32'h81a3, 1);
    chk({31'h0, irq}, 32'h0);
    src.pulse();
    chk({31'h0, irq}, 32'h1);
    rdc(ICU_OFS_IRQ, 32'h57);
    wr(ICU_OFS_IRQ, 32'h55);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    sleep <= 1'b1;
    burst(32'h8007, 1);
    chk({31'h0, irq}, 32'h1);
    rdc(ICU_OFS_CTRL, 32'h8007);
    sleep <= 1'b0;
  endtask
  // paused capture: halt in idle, then debug freeze
  task automatic t_pause();
    idle <= 1'b1;
    burst(32'ha183, 1);
    rdc(ICU_OFS_CTRL, 32'ha183);
    wr(ICU_OFS_CLR, 32'h2000);
    src.pulse();
    rdc(ICU_OFS_BUF, 32'h1);
    idle <= 1'b0;
    halt <= 1'b1;
    wr(ICU_OFS_SET, 32'h4000);
    src.pulse();
    rdc(ICU_OFS_CTRL, 32'hc183);
    halt <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_sim();
  end
  // reset for 5 cycles, then the scenarios
  initial begin
    {nrst, cyc, stb, we, sleep, idle, halt} = 7'h0;
    adr = 8'h0;
    sel = 4'hf;
    dat_i = 32'h0;
    tba = 32'h0;
    tbb = 32'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_modes();
    t_ovf();
    t_first();
    t_irq();
    t_pause();
    end_sim();
  end
endmodule
